/* File: src/dacu_top.sv */
`timescale 1ns/1ns
module dacu_top
    import dacu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmp0_flag,
    input  wire logic        cmp1_flag,
    input  wire logic        ext_irq0_flag,
    input  wire logic        tmr1_ovf_flag,
    input  wire logic        tmr1_capt_flag,
    output logic             converter_on,
    output logic [9:0]       converter_value,
    output logic             value_update
);

    typedef struct packed {
        logic [7:0] converter_control_reg;
        logic [7:0] value_lower_byte;
        logic [7:0] value_upper_byte;
        logic [7:0] lower_hold;
        logic [7:0] upper_hold;
        logic       align_hold;
        logic       lower_pending;
        logic [9:0] shadow;
        logic       on;
        logic       update;
    } dacu_top_state_t;

    dacu_top_state_t s_reg;
    dacu_top_state_t s_next;

    dacu_reg_if rif ();

    logic       trig_edge;
    logic       wr_ctrl;
    logic       wr_lo;
    logic       wr_hi;
    logic       ctl_on;
    logic       ctl_auto;
    logic       ctl_left;
    logic [2:0] ctl_sel;
    logic       upd_write;
    logic       upd_trig;

    dacu_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rif     (rif.bus)
    );

    dacu_trig u_trig (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .event_flags           ({tmr1_capt_flag, tmr1_ovf_flag, ext_irq0_flag, cmp1_flag, cmp0_flag}),
        .update_trigger_select (ctl_sel),
        .auto_update_enable    (ctl_auto),
        .busy                  (s_reg.update),
        .trig_edge             (trig_edge)
    );

    always_comb begin
        ctl_on   = s_reg.converter_control_reg[DACU_EN_BIT];
        ctl_auto = s_reg.converter_control_reg[DACU_AUTO_BIT];
        ctl_left = s_reg.converter_control_reg[DACU_ALIGN_BIT];
        ctl_sel  = s_reg.converter_control_reg[DACU_SEL_LSB +: 3];
        wr_ctrl  = rif.wr_en && rif.wr_strb[0] && dacu_hit(rif.wr_addr, DACU_OFF_CONTROL);
        wr_lo    = rif.wr_en && rif.wr_strb[0] && dacu_hit(rif.wr_addr, DACU_OFF_LOWER);
        wr_hi    = rif.wr_en && rif.wr_strb[0] && dacu_hit(rif.wr_addr, DACU_OFF_UPPER);
        rif.wr_ok = dacu_hit(rif.wr_addr, DACU_OFF_CONTROL) || dacu_hit(rif.wr_addr, DACU_OFF_LOWER) ||
                    dacu_hit(rif.wr_addr, DACU_OFF_UPPER) || dacu_hit(rif.wr_addr, DACU_OFF_STATUS);
        rif.rd_ok   = 1'b1;
        rif.rd_data = 32'h0000_0000;
        if (dacu_hit(rif.rd_addr, DACU_OFF_CONTROL)) begin
            rif.rd_data[7:0] = s_reg.converter_control_reg;
        end else if (dacu_hit(rif.rd_addr, DACU_OFF_LOWER)) begin
            rif.rd_data[7:0] = s_reg.value_lower_byte;
        end else if (dacu_hit(rif.rd_addr, DACU_OFF_UPPER)) begin
            rif.rd_data[7:0] = s_reg.value_upper_byte;
        end else if (dacu_hit(rif.rd_addr, DACU_OFF_STATUS)) begin
            rif.rd_data[DACU_STAT_BUSY]    = s_reg.update;
            rif.rd_data[DACU_STAT_LO_PEND] = s_reg.lower_pending;
        end else begin
            rif.rd_ok = 1'b0;
        end

        upd_write = ctl_on && !ctl_auto && wr_hi; // see RULE5
        upd_trig  = ctl_on && ctl_auto && trig_edge; // see RULE4

        s_next        = s_reg;
        s_next.update = 1'b0;
        s_next.on     = ctl_on; // see RULE2
        if (wr_ctrl) begin
            // Reserved bits 3 and 1 never store, so they read back as zero.
            s_next.converter_control_reg = rif.wr_data[7:0] & DACU_CTRL_WMASK;
        end
        if (wr_lo) begin
            // The lower byte only parks here until the upper byte commits it. see RULE14
            s_next.value_lower_byte = rif.wr_data[7:0];
            s_next.lower_pending    = 1'b1;
        end
        if (wr_hi) begin
            // The pair and the alignment bit are frozen together at the upper byte write. see RULE12
            s_next.value_upper_byte = rif.wr_data[7:0];
            s_next.upper_hold       = rif.wr_data[7:0];
            s_next.lower_hold       = s_reg.value_lower_byte;
            s_next.align_hold       = ctl_left;
            s_next.lower_pending    = 1'b0;
        end
        // With the converter off neither path loads the shadow. see RULE3
        if (upd_write) begin
            s_next.shadow = dacu_value(rif.wr_data[7:0], s_reg.value_lower_byte, ctl_left); // see RULE15
            s_next.update = 1'b1; // see RULE16
        end else if (upd_trig) begin
            s_next.shadow = dacu_value(s_reg.upper_hold, s_reg.lower_hold, s_reg.align_hold); // see RULE13
            s_next.update = 1'b1; // see RULE16
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg                       <= '0;
            s_reg.converter_control_reg <= DACU_CTRL_RESET;
            s_reg.value_lower_byte      <= DACU_BYTE_RESET;
            s_reg.value_upper_byte      <= DACU_BYTE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign converter_on    = s_reg.on;
    assign converter_value = s_reg.shadow; // see RULE1
    assign value_update    = s_reg.update;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_manual_write;
        ctl_on && !ctl_auto && wr_hi;
    endsequence

    sequence s_loaded;
        value_update && converter_on;
    endsequence

    property p_manual_update;
        s_manual_write |=> s_loaded and
            (converter_value == dacu_value($past(rif.wr_data[7:0]), $past(s_reg.value_lower_byte), $past(ctl_left)));
    endproperty
    a_manual_update: assert property (p_manual_update) else $error("upper write did not load value"); // see RULE5

    property p_off_holds;
        !ctl_on |=> !value_update && $stable(converter_value);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("value changed while disabled"); // see RULE3

    property p_auto_needs_edge;
        ctl_on && ctl_auto && !trig_edge |=> !value_update;
    endproperty
    a_auto_needs_edge: assert property (p_auto_needs_edge) else $error("auto update without edge"); // see RULE4

    property p_edge_loads_hold;
        ctl_on && ctl_auto && trig_edge |=> s_loaded and
            (converter_value == dacu_value($past(s_reg.upper_hold), $past(s_reg.lower_hold), $past(s_reg.align_hold)));
    endproperty
    a_edge_loads_hold: assert property (p_edge_loads_hold) else $error("trigger edge did not load"); // see RULE13

    // Watching the load itself, not the gated edge, so a broken busy gate cannot hide behind its own term.
    property p_busy_ignores;
        value_update && ctl_auto |=> !value_update;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("edge accepted while busy"); // see RULE10

    // Flags that stay put after an edge keep the selected level high, so no second load may follow.
    property p_level_no_retrigger;
        ctl_auto && trig_edge ##1
            (ctl_auto && $stable(ctl_sel) &&
             $stable({tmr1_capt_flag, tmr1_ovf_flag, ext_irq0_flag, cmp1_flag, cmp0_flag}))[*2] |-> !trig_edge;
    endproperty
    a_level_no_retrigger: assert property (p_level_no_retrigger) else $error("held trigger loaded again"); // see RULE9

    property p_lower_no_effect;
        wr_lo && !ctl_auto |=> $stable(converter_value);
    endproperty
    a_lower_no_effect: assert property (p_lower_no_effect) else $error("lower write moved value"); // see RULE14

    property p_align_frozen;
        wr_hi |=> s_reg.align_hold == $past(ctl_left) && !s_reg.lower_pending;
    endproperty
    a_align_frozen: assert property (p_align_frozen) else $error("alignment not captured"); // see RULE12

    property p_reserved_sel;
        ctl_auto && (ctl_sel == 3'h3 || ctl_sel == 3'h4 || ctl_sel == 3'h5) |-> !trig_edge;
    endproperty
    a_reserved_sel: assert property (p_reserved_sel) else $error("reserved select triggered"); // see RULE7

    property p_manual_ignores_trigger;
        !ctl_auto |-> !trig_edge;
    endproperty
    a_manual_ignores_trigger: assert property (p_manual_ignores_trigger) else $error("select used in write mode"); // see RULE6

    property p_update_one_cycle;
        value_update |=> !value_update || $past(upd_write || upd_trig);
    endproperty
    a_update_one_cycle: assert property (p_update_one_cycle) else $error("busy outlived load"); // see RULE16

endmodule : dacu_top

/* File: src/dacu_pkg.sv */
// Summary of operation
// RULE1: The converter takes a 10-bit input value built from an upper and a lower data byte register.
// RULE2: While the enable bit is set, the converter follows the data registers as the control settings say.
// RULE3: Clearing the enable bit stops every further update of the converter input.
// RULE4: With auto-update on, the converter input is loaded only on a rising edge of the selected trigger.
// RULE5: With auto-update off, every write of the upper data byte loads the converter input.
// RULE6: The three-bit trigger select field matters only while auto-update is on.
// RULE7: Trigger codes are 0 comparator 0, 1 comparator 1, 2 external request 0, 6 timer overflow, 7 timer capture.
// RULE8: The trigger is the rising edge of the raw event flag, whatever its interrupt enables say.
// RULE9: A trigger that is still high when a load completes does not start another; a new rising edge is needed.
// RULE10: A rising edge that arrives while a load is in progress is ignored.
// RULE11: Software clears the selected event flag after each event so that the next one makes a new edge.
// RULE12: The alignment bit picks left or right adjusted data and takes effect at the next upper byte write.
// RULE13: The converted value sits in hidden shadow registers loaded only at an update point.
// RULE14: A lower byte write has no effect until the upper byte is written, so software writes the lower byte first.
// RULE15: Right adjusted puts bits 9:8 in upper bits 1:0; left adjusted puts bits 9:2 in the upper byte, 1:0 in lower 7:6.
// RULE16: The shadow is loaded one clock after the update condition and the load counts as in progress for that cycle.
package dacu_pkg;

    localparam int          DACU_ADDR_W       = 8;
    localparam int          DACU_DATA_W       = 32;
    localparam int          DACU_VALUE_W      = 10;

    localparam logic [7:0]  DACU_OFF_CONTROL  = 8'h00;
    localparam logic [7:0]  DACU_OFF_LOWER    = 8'h04;
    localparam logic [7:0]  DACU_OFF_UPPER    = 8'h08;
    localparam logic [7:0]  DACU_OFF_STATUS   = 8'h0c;

    localparam logic [7:0]  DACU_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  DACU_CTRL_WMASK   = 8'hf5;
    localparam int          DACU_AUTO_BIT     = 7;
    localparam int          DACU_SEL_LSB      = 4;
    localparam int          DACU_ALIGN_BIT    = 2;
    localparam int          DACU_EN_BIT       = 0;
    localparam logic [7:0]  DACU_BYTE_RESET   = 8'h00;

    localparam int          DACU_STAT_BUSY    = 0;
    localparam int          DACU_STAT_LO_PEND = 1;

    localparam logic [2:0]  DACU_SEL_CMP0     = 3'h0;
    localparam logic [2:0]  DACU_SEL_CMP1     = 3'h1;
    localparam logic [2:0]  DACU_SEL_EXT0     = 3'h2;
    localparam logic [2:0]  DACU_SEL_TOVF     = 3'h6;
    localparam logic [2:0]  DACU_SEL_TCAPT    = 3'h7;

    localparam logic [1:0]  DACU_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  DACU_RESP_SLVERR  = 2'h2;

    function automatic logic [9:0] dacu_value(input logic [7:0] upper, input logic [7:0] lower, input logic left);
        if (left) begin
            dacu_value = {upper, lower[7:6]};
        end else begin
            dacu_value = {upper[1:0], lower};
        end
    endfunction : dacu_value

    function automatic logic dacu_hit(input logic [7:0] addr, input logic [7:0] off);
        dacu_hit = (addr[7:2] == off[7:2]);
    endfunction : dacu_hit

endpackage : dacu_pkg

/* File: src/dacu_reg_if.sv */
`timescale 1ns/1ns
interface dacu_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : dacu_reg_if

/* File: src/dacu_axil.sv */
`timescale 1ns/1ns
module dacu_axil
    import dacu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    dacu_reg_if.bus          rif
);

    typedef struct packed {
        logic        awready;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        wready;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dacu_axil_state_t;

    dacu_axil_state_t s_reg;
    dacu_axil_state_t s_next;

    // Address and data are parked separately so the master may offer them in either order.
    always_comb begin
        s_next      = s_reg;
        rif.wr_en   = 1'b0;
        rif.wr_addr = s_reg.aw_addr;
        rif.wr_data = s_reg.w_data;
        rif.wr_strb = s_reg.w_strb;
        rif.rd_addr = araddr;
        if (awvalid && s_reg.awready) begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_full = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
            rif.wr_en      = 1'b1;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = rif.wr_ok ? DACU_RESP_OKAY : DACU_RESP_SLVERR;
            s_next.aw_full = 1'b0;
            s_next.w_full  = 1'b0;
        end
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rif.rd_ok ? rif.rd_data : 32'h0000_0000;
            s_next.rresp  = rif.rd_ok ? DACU_RESP_OKAY : DACU_RESP_SLVERR;
        end
        s_next.awready = !s_next.aw_full && !s_next.bvalid;
        s_next.wready  = !s_next.w_full && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = s_reg.awready;
    assign wready  = s_reg.wready;
    assign bvalid  = s_reg.bvalid;
    assign bresp   = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid  = s_reg.rvalid;
    assign rdata   = s_reg.rdata;
    assign rresp   = s_reg.rresp;

endmodule : dacu_axil

/* File: src/dacu_trig.sv */
`timescale 1ns/1ns
module dacu_trig
    import dacu_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [4:0] event_flags,
    input  wire logic [2:0] update_trigger_select,
    input  wire logic       auto_update_enable,
    input  wire logic       busy,
    output logic            trig_edge
);

    typedef struct packed {
        logic prev;
    } dacu_trig_state_t;

    dacu_trig_state_t s_reg;
    dacu_trig_state_t s_next;
    logic             level;

    // Raw flags are watched, so a masked interrupt still triggers. see RULE8
    always_comb begin
        case (update_trigger_select) // see RULE7
            DACU_SEL_CMP0:  level = event_flags[0];
            DACU_SEL_CMP1:  level = event_flags[1];
            DACU_SEL_EXT0:  level = event_flags[2];
            DACU_SEL_TOVF:  level = event_flags[3];
            DACU_SEL_TCAPT: level = event_flags[4];
            default:        level = 1'b0;
        endcase
        s_next.prev = level;
        // A level held high makes no second edge, and edges during a load are dropped. see RULE9 see RULE10
        trig_edge = auto_update_enable && level && !s_reg.prev && !busy; // see RULE6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : dacu_trig

/* File: bench/dac_update_control_test.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module dac_update_control_test;
    import dacu_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, arvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, converter_on, value_update;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  converter_value, v;
    logic [4:0]  flags;
    logic [9:0]  exp_val[$];
    logic [33:0] exp_rd[$];
    logic [1:0]  exp_b[$];
    logic [2:0]  sels[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
    int          n_errors, compares, seed, cycles;

    dacu_top u_dacu_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .cmp0_flag(flags[0]), .cmp1_flag(flags[1]), .ext_irq0_flag(flags[2]),
        .tmr1_ovf_flag(flags[3]), .tmr1_capt_flag(flags[4]),
        .converter_on(converter_on), .converter_value(converter_value), .value_update(value_update)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic final_report();
        if (exp_val.size() != 0 || exp_rd.size() != 0 || exp_b.size() != 0) begin
            n_errors++;
        end
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // The bench keeps bready and rready high, so each task ends on the edge that takes the answer.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
        logic [31:0] rnd;
        rnd = $random(seed);
        exp_b.push_back(r);
        awaddr  <= a;
        wdata   <= {rnd[23:0], d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_rd.push_back({r, 24'h000000, d});
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
    endtask : rd

    task automatic pulse(input int idx, input int hi);
        flags[idx] <= 1'b1;
        repeat (hi) @(posedge aclk);
        flags[idx] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : pulse

    // Any load with no note waiting is an unwanted update and counts as a mismatch.
    always @(posedge aclk) begin
        if (aresetn) begin
            if (value_update === 1'b1) begin
                if (exp_val.size() == 0) begin
                    `CHK(value_update, 1'b0)
                end else begin
                    `CHK(converter_value, exp_val.pop_front())
                end
            end
            if (bvalid === 1'b1 && exp_b.size() != 0) begin
                `CHK(bresp, exp_b.pop_front())
            end
            if (rvalid === 1'b1 && exp_rd.size() != 0) begin
                `CHK({rresp, rdata}, exp_rd.pop_front())
            end
        end
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        seed = 81;
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {awaddr, araddr, wdata, wstrb, flags} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(converter_value, 10'h000)
        `CHK(converter_on, 1'b0)
        rd(DACU_OFF_CONTROL, 8'h00, DACU_RESP_OKAY);
        rd(DACU_OFF_LOWER, 8'h00, DACU_RESP_OKAY);
        rd(DACU_OFF_UPPER, 8'h00, DACU_RESP_OKAY);
        rd(8'h10, 8'h00, DACU_RESP_SLVERR);
        wr(8'h10, 8'hff, 4'h1, DACU_RESP_SLVERR);
        wr(DACU_OFF_STATUS, 8'hff, 4'h1, DACU_RESP_OKAY);
        rd(DACU_OFF_STATUS, 8'h00, DACU_RESP_OKAY);
        wr(DACU_OFF_CONTROL, 8'hff, 4'h1, DACU_RESP_OKAY);
        rd(DACU_OFF_CONTROL, 8'hf5, DACU_RESP_OKAY);
        $display("test reset_and_map done");
        // Select field set while auto mode is off must not matter.
        wr(DACU_OFF_CONTROL, 8'h71, 4'h1, DACU_RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(converter_on, 1'b1)
        for (int i = 0; i < 6; i++) begin
            v = 10'($random(seed));
            wr(DACU_OFF_LOWER, v[7:0], 4'h1, DACU_RESP_OKAY);
            rd(DACU_OFF_STATUS, 8'h02, DACU_RESP_OKAY);
            pulse(4, 1);
            exp_val.push_back(v);
            wr(DACU_OFF_UPPER, {6'h00, v[9:8]}, 4'h1, DACU_RESP_OKAY);
            rd(DACU_OFF_LOWER, v[7:0], DACU_RESP_OKAY);
        end
        wr(DACU_OFF_UPPER, 8'h02, 4'h0, DACU_RESP_OKAY);
        $display("test write_mode done");
        wr(DACU_OFF_CONTROL, 8'h05, 4'h1, DACU_RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            v = 10'($random(seed));
            wr(DACU_OFF_LOWER, {v[1:0], 6'h00}, 4'h1, DACU_RESP_OKAY);
            exp_val.push_back(v);
            wr(DACU_OFF_UPPER, v[9:2], 4'h1, DACU_RESP_OKAY);
        end
        // Dropping the alignment bit loads nothing until the next upper byte write.
        wr(DACU_OFF_CONTROL, 8'h01, 4'h1, DACU_RESP_OKAY);
        repeat (4) @(posedge aclk);
        exp_val.push_back({2'h3, v[1:0], 6'h00});
        wr(DACU_OFF_UPPER, 8'h03, 4'h1, DACU_RESP_OKAY);
        $display("test alignment done");
        wr(DACU_OFF_CONTROL, 8'h00, 4'h1, DACU_RESP_OKAY);
        wr(DACU_OFF_UPPER, 8'h01, 4'h1, DACU_RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(converter_on, 1'b0)
        $display("test disable done");
        for (int k = 0; k < 5; k++) begin
            wr(DACU_OFF_CONTROL, {1'b1, sels[k], 4'h1}, 4'h1, DACU_RESP_OKAY);
            v = 10'($random(seed));
            wr(DACU_OFF_LOWER, v[7:0], 4'h1, DACU_RESP_OKAY);
            wr(DACU_OFF_UPPER, {6'h00, v[9:8]}, 4'h1, DACU_RESP_OKAY);
            wr(DACU_OFF_LOWER, ~v[7:0], 4'h1, DACU_RESP_OKAY);
            exp_val.push_back(v);
            pulse(k, 6);
            for (int j = 0; j < 5; j++) begin
                if (j != k) begin
                    pulse(j, 1);
                end
            end
        end
        for (int k = 3; k < 6; k++) begin
            wr(DACU_OFF_CONTROL, {1'b1, k[2:0], 4'h1}, 4'h1, DACU_RESP_OKAY);
            for (int j = 0; j < 5; j++) begin
                pulse(j, 1);
            end
        end
        $display("test auto_trigger done");
        // A reset in mid-run must clear a loaded shadow and an enabled control word.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(converter_value, 10'h000)
        `CHK(converter_on, 1'b0)
        rd(DACU_OFF_CONTROL, 8'h00, DACU_RESP_OKAY);
        $display("test mid_reset done");
        repeat (4) @(posedge aclk);
        final_report();
    end
endmodule : dac_update_control_test
